// ===== include/mbc_params.svh
// constants for the microsequencer branch control block
// assumes a single 10 MHz clock and a synchronous active-high reset
//
// How it works
// - simple loop nonzero: decrement, branch data
// - simple loop at zero: sequential, hold
// - loop opcodes ignore the test result
// - loops clear selected match flag when nonzero
// - nested loop nonzero: decrement, branch data
// - nested loop zero: return into count, sequential
// - failed test holds state except the combined decrement, sequential mostly
// - passing branch or call clears selected flag
// - branch when count zero, clear flag then
// - masked value is test anded with data
// - count-wait: wait decrementing, then load count
// - combined: pass branch, fail wait-decrement
// - push saves incremented address, loads count except plain push
// - test select picks one of eight
// - polarity bit inverts the selected condition
// - reset forces fetch of location 63
// - match flag set on masked equals constant
`ifndef MBC_PARAMS_SVH
`define MBC_PARAMS_SVH

`define MBC_AW            6
`define MBC_RESET_ADDR    6'h3f
`define MBC_COUNT_RESET   6'h00
`define MBC_RETURN_RESET  6'h00

// opcodes
`define MBC_OP_RET_LOAD_DATA     5'h00
`define MBC_OP_RET_NEST_LOAD     5'h01
`define MBC_OP_RET               5'h02
`define MBC_OP_RET_NEST          5'h03
`define MBC_OP_LOAD_DATA         5'h04
`define MBC_OP_LOAD_DATA_NEST    5'h05
`define MBC_OP_LOAD_MASKED       5'h06
`define MBC_OP_LOAD_MASKED_NEST  5'h07
`define MBC_OP_LOOP              5'h08
`define MBC_OP_DEC               5'h09
`define MBC_OP_LOOP_NEST         5'h0a
`define MBC_OP_BRANCH_ZERO       5'h0b
`define MBC_OP_WAIT_LOAD_DATA    5'h0c
`define MBC_OP_CONTINUE          5'h0d
`define MBC_OP_WAIT_LOAD_MASKED  5'h0e
`define MBC_OP_BRANCH_MASKED     5'h0f
`define MBC_OP_CMP_HI            3'h4
`define MBC_OP_PUSH_LOAD_DATA    5'h14
`define MBC_OP_PUSH              5'h15
`define MBC_OP_PUSH_LOAD_MASKED  5'h16
`define MBC_OP_PUSH_NEST         5'h17
`define MBC_OP_FORK              5'h18
`define MBC_OP_BRANCH_DATA       5'h19
`define MBC_OP_WAIT_BRANCH       5'h1a
`define MBC_OP_BRANCH_OR_WAIT    5'h1b
`define MBC_OP_CALL_DATA         5'h1c
`define MBC_OP_CALL_DATA_NEST    5'h1d
`define MBC_OP_CALL_MASKED       5'h1e
`define MBC_OP_CALL_MASKED_NEST  5'h1f

// test select codes
`define MBC_SEL_CONDITION        3'h6
`define MBC_SEL_MATCH            3'h7

// apb map
`define MBC_APB_AW               12
`define MBC_REG_CONTROL          12'h000
`define MBC_REG_STATUS           12'h004
`define MBC_CTRL_HALT_BIT        0
`define MBC_CTRL_RESET           32'h0000_0000

`endif

// ===== include/mbc_pkg.sv
// types for the microsequencer branch control block
// assumes mbc_params.svh for all numeric constants
package mbc_pkg;

  typedef enum logic [2:0] {
    mbc_src_current,
    mbc_src_increment,
    mbc_src_data,
    mbc_src_masked,
    mbc_src_return
  } mbc_addr_src_t;

  typedef enum logic [2:0] {
    mbc_cnt_hold,
    mbc_cnt_dec,
    mbc_cnt_data,
    mbc_cnt_masked,
    mbc_cnt_return
  } mbc_count_op_t;

  typedef enum logic [1:0] {
    mbc_ret_hold,
    mbc_ret_increment,
    mbc_ret_count
  } mbc_return_op_t;

endpackage : mbc_pkg

// ===== logic/mbc_cond_select.sv
// test condition selector with polarity
// assumes inputs synchronous to the caller's clock; purely combinational
`timescale 1ns/1ps
module mbc_cond_select (
  input  wire logic [5:0] i_test,
  input  wire logic       i_condition_input,
  input  wire logic       i_match_flag,
  input  wire logic [2:0] i_test_select,
  input  wire logic       i_test_polarity,
  output logic            o_pass
);
  logic [7:0] conditions;

  // eight candidate conditions
  assign conditions = {i_match_flag, i_condition_input, i_test};
  // polarity 1 passes on a low condition
  assign o_pass = conditions[i_test_select] ^ i_test_polarity;
endmodule : mbc_cond_select

// ===== logic/mbc_mask_compare.sv
// masked test value and constant compare
// assumes inputs synchronous to the caller's clock; purely combinational
`timescale 1ns/1ps
module mbc_mask_compare (
  input  wire logic [5:0] i_test,
  input  wire logic [5:0] i_mask,
  input  wire logic [5:0] i_constant,
  output logic [5:0]      o_masked,
  output logic            o_match
);
  assign o_masked = i_test & i_mask;
  assign o_match  = (o_masked == i_constant);
endmodule : mbc_mask_compare

// ===== logic/mbc_top.sv
// next-address and register-update control of a 64-word microsequencer
// assumes instruction fields come from an outside pipeline register
// and are stable in the cycle they are decoded; apb master drives registers
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "mbc_params.svh"
module mbc_top (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst,
  input  wire logic [4:0]             i_opcode,
  input  wire logic                   i_test_polarity,
  input  wire logic [2:0]             i_test_select,
  input  wire logic [5:0]             i_data_field,
  input  wire logic [5:0]             i_test,
  input  wire logic                   i_condition_input,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`MBC_APB_AW-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic [31:0]                 o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  output logic [5:0]                  o_microaddress_counter,
  output logic [5:0]                  o_loop_count_register,
  output logic [5:0]                  o_return_stack_register,
  output logic                        o_match_flag,
  output logic                        o_count_zero
);

  // ==========================================================
  // state
  // ==========================================================
  logic [5:0]  microaddress_counter;
  logic [5:0]  loop_count_register;
  logic [5:0]  return_stack_register;
  logic        match_flag;
  logic [31:0] control;
  logic        halt;

  logic [5:0]  incremented;
  logic [5:0]  masked_test_value;
  logic [5:0]  constant_field;
  logic        masked_match;
  logic        pass;
  logic        count_zero;
  logic        match_selected;

  mbc_pkg::mbc_addr_src_t  next_address_select;
  mbc_pkg::mbc_count_op_t  next_count_op;
  mbc_pkg::mbc_return_op_t next_return_op;
  logic                    next_clear_match;
  logic                    next_set_match;

  logic [5:0] next_address;
  logic [5:0] next_loop_count;
  logic [5:0] next_return_stack;

  assign halt           = control[`MBC_CTRL_HALT_BIT];
  assign incremented    = microaddress_counter + 6'h01;
  assign count_zero     = (loop_count_register == 6'h00);
  assign match_selected = (i_test_select == `MBC_SEL_MATCH);
  // constant field overlaps opcode low bits, polarity and test select
  assign constant_field = {i_opcode[1:0], i_test_polarity, i_test_select};

  // ==========================================================
  // condition and mask logic
  // ==========================================================
  mbc_cond_select u_cond (
    .i_test            (i_test),
    .i_condition_input (i_condition_input),
    .i_match_flag      (match_flag),
    .i_test_select     (i_test_select),
    .i_test_polarity   (i_test_polarity),
    .o_pass            (pass)
  );

  mbc_mask_compare u_mask (
    .i_test     (i_test),
    .i_mask     (i_data_field),
    .i_constant (constant_field),
    .o_masked   (masked_test_value),
    .o_match    (masked_match)
  );

  // ==========================================================
  // instruction decode
  // ==========================================================
  always_comb begin
    next_address_select = mbc_pkg::mbc_src_increment;
    next_count_op       = mbc_pkg::mbc_cnt_hold;
    next_return_op      = mbc_pkg::mbc_ret_hold;
    next_clear_match    = 1'b0;
    next_set_match      = 1'b0;
    case (i_opcode)
      `MBC_OP_RET_LOAD_DATA: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_return;
          next_count_op       = mbc_pkg::mbc_cnt_data;
        end
      end
      `MBC_OP_RET_NEST_LOAD: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_return;
          next_return_op      = mbc_pkg::mbc_ret_count;
          next_count_op       = mbc_pkg::mbc_cnt_data;
        end
      end
      `MBC_OP_RET: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_return;
        end
      end
      `MBC_OP_RET_NEST: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_return;
          next_return_op      = mbc_pkg::mbc_ret_count;
        end
      end
      `MBC_OP_LOAD_DATA: begin
        if (pass) begin
          next_count_op = mbc_pkg::mbc_cnt_data;
        end
      end
      `MBC_OP_LOAD_DATA_NEST: begin
        if (pass) begin
          next_return_op = mbc_pkg::mbc_ret_count;
          next_count_op  = mbc_pkg::mbc_cnt_data;
        end
      end
      `MBC_OP_LOAD_MASKED: begin
        if (pass) begin
          next_count_op = mbc_pkg::mbc_cnt_masked;
        end
      end
      `MBC_OP_LOAD_MASKED_NEST: begin
        if (pass) begin
          next_return_op = mbc_pkg::mbc_ret_count;
          next_count_op  = mbc_pkg::mbc_cnt_masked;
        end
      end
      `MBC_OP_DEC: begin
        if (pass) begin
          next_count_op = mbc_pkg::mbc_cnt_dec;
        end
      end
      `MBC_OP_LOOP: begin
        // test result not consulted
        if (!count_zero) begin
          next_address_select = mbc_pkg::mbc_src_data;
          next_count_op       = mbc_pkg::mbc_cnt_dec;
          next_clear_match    = match_selected;
        end // zero case keeps defaults
      end
      `MBC_OP_LOOP_NEST: begin
        if (!count_zero) begin
          next_address_select = mbc_pkg::mbc_src_data;
          next_count_op       = mbc_pkg::mbc_cnt_dec;
          next_clear_match    = match_selected;
        end else begin
          next_count_op = mbc_pkg::mbc_cnt_return;
        end
      end
      `MBC_OP_BRANCH_ZERO: begin
        if (count_zero) begin
          next_address_select = mbc_pkg::mbc_src_data;
          next_clear_match    = match_selected;
        end
      end
      `MBC_OP_WAIT_LOAD_DATA: begin
        if (!count_zero) begin
          next_address_select = mbc_pkg::mbc_src_current;
          next_count_op       = mbc_pkg::mbc_cnt_dec;
        end else begin
          next_count_op = mbc_pkg::mbc_cnt_data;
        end
      end
      `MBC_OP_WAIT_LOAD_MASKED: begin
        if (!count_zero) begin
          next_address_select = mbc_pkg::mbc_src_current;
          next_count_op       = mbc_pkg::mbc_cnt_dec;
        end else begin
          next_count_op = mbc_pkg::mbc_cnt_masked;
        end
      end
      `MBC_OP_CONTINUE: begin
        next_address_select = mbc_pkg::mbc_src_increment;
      end
      `MBC_OP_BRANCH_MASKED: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_masked;
          next_clear_match    = match_selected;
        end
      end
      `MBC_OP_PUSH_LOAD_DATA: begin
        if (pass) begin
          next_return_op = mbc_pkg::mbc_ret_increment;
          next_count_op  = mbc_pkg::mbc_cnt_data;
        end
      end
      `MBC_OP_PUSH: begin
        if (pass) begin
          next_return_op = mbc_pkg::mbc_ret_increment;
        end
      end
      `MBC_OP_PUSH_LOAD_MASKED: begin
        if (pass) begin
          next_return_op = mbc_pkg::mbc_ret_increment;
          next_count_op  = mbc_pkg::mbc_cnt_masked;
        end
      end
      `MBC_OP_PUSH_NEST: begin
        if (pass) begin
          next_return_op = mbc_pkg::mbc_ret_increment;
          next_count_op  = mbc_pkg::mbc_cnt_return;
        end
      end
      `MBC_OP_FORK: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_data;
          next_clear_match    = match_selected;
        end else begin
          next_address_select = mbc_pkg::mbc_src_return;
        end
      end
      `MBC_OP_BRANCH_DATA: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_data;
          next_clear_match    = match_selected;
        end
      end
      `MBC_OP_WAIT_BRANCH: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_data;
          next_clear_match    = match_selected;
        end else begin
          next_address_select = mbc_pkg::mbc_src_current;
        end
      end
      `MBC_OP_BRANCH_OR_WAIT: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_data;
          next_clear_match    = match_selected;
        end else if (!count_zero) begin
          next_address_select = mbc_pkg::mbc_src_current;
          next_count_op       = mbc_pkg::mbc_cnt_dec;
        end
      end
      `MBC_OP_CALL_DATA: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_data;
          next_return_op      = mbc_pkg::mbc_ret_increment;
          next_clear_match    = match_selected;
        end
      end
      `MBC_OP_CALL_DATA_NEST: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_data;
          next_return_op      = mbc_pkg::mbc_ret_increment;
          next_count_op       = mbc_pkg::mbc_cnt_return;
          next_clear_match    = match_selected;
        end
      end
      `MBC_OP_CALL_MASKED: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_masked;
          next_return_op      = mbc_pkg::mbc_ret_increment;
          next_clear_match    = match_selected;
        end
      end
      `MBC_OP_CALL_MASKED_NEST: begin
        if (pass) begin
          next_address_select = mbc_pkg::mbc_src_masked;
          next_return_op      = mbc_pkg::mbc_ret_increment;
          next_count_op       = mbc_pkg::mbc_cnt_return;
          next_clear_match    = match_selected;
        end
      end
      default: begin
        // compare group 10..13, sequential
        if (i_opcode[4:2] == `MBC_OP_CMP_HI) begin
          next_set_match = masked_match;
        end
      end
    endcase
  end

  // ==========================================================
  // next-value muxes
  // ==========================================================
  always_comb begin
    case (next_address_select)
      mbc_pkg::mbc_src_current: next_address = microaddress_counter;
      mbc_pkg::mbc_src_data:    next_address = i_data_field;
      mbc_pkg::mbc_src_masked:  next_address = masked_test_value;
      mbc_pkg::mbc_src_return:  next_address = return_stack_register;
      default:                  next_address = incremented;
    endcase
  end

  always_comb begin
    case (next_count_op)
      mbc_pkg::mbc_cnt_dec:    next_loop_count = loop_count_register - 6'h01;
      mbc_pkg::mbc_cnt_data:   next_loop_count = i_data_field;
      mbc_pkg::mbc_cnt_masked: next_loop_count = masked_test_value;
      mbc_pkg::mbc_cnt_return: next_loop_count = return_stack_register;
      default:                 next_loop_count = loop_count_register;
    endcase
  end

  always_comb begin
    case (next_return_op)
      mbc_pkg::mbc_ret_increment: next_return_stack = incremented;
      mbc_pkg::mbc_ret_count:     next_return_stack = loop_count_register;
      default:                    next_return_stack = return_stack_register;
    endcase
  end

  // ==========================================================
  // sequencer registers
  // ==========================================================
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      microaddress_counter <= `MBC_RESET_ADDR;
    end else if (!halt) begin
      microaddress_counter <= next_address;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      loop_count_register   <= `MBC_COUNT_RESET;
      return_stack_register <= `MBC_RETURN_RESET;
    end else if (!halt) begin
      loop_count_register   <= next_loop_count;
      return_stack_register <= next_return_stack;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      match_flag <= 1'b0;
    end else if (!halt) begin
      if (next_set_match) begin
        match_flag <= 1'b1;
      end else if (next_clear_match) begin
        match_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_microaddress_counter  <= `MBC_RESET_ADDR;
      o_loop_count_register   <= `MBC_COUNT_RESET;
      o_return_stack_register <= `MBC_RETURN_RESET;
      o_match_flag            <= 1'b0;
      o_count_zero            <= 1'b1;
    end else begin
      o_microaddress_counter  <= microaddress_counter;
      o_loop_count_register   <= loop_count_register;
      o_return_stack_register <= return_stack_register;
      o_match_flag            <= match_flag;
      o_count_zero            <= count_zero;
    end
  end

  // ==========================================================
  // apb slave
  // ==========================================================
  logic access;
  logic known_addr;

  assign access     = i_psel & i_penable;
  assign known_addr = (i_paddr == `MBC_REG_CONTROL) | (i_paddr == `MBC_REG_STATUS);

  // one wait state, then pready for a single cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= access & ~o_pready;
      o_pslverr <= access & ~o_pready & ~known_addr;
      if (access & ~o_pready & ~i_pwrite) begin
        case (i_paddr)
          `MBC_REG_CONTROL: o_prdata <= control;
          `MBC_REG_STATUS:  o_prdata <= {7'h00, count_zero, match_flag, 1'b0,
                                         return_stack_register, 2'h0,
                                         loop_count_register, 2'h0,
                                         microaddress_counter};
          default:          o_prdata <= 32'h0000_0000;
        endcase
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      control <= `MBC_CTRL_RESET;
    end else if (access & o_pready & i_pwrite & (i_paddr == `MBC_REG_CONTROL)) begin
      control <= {31'h0, i_pwdata[`MBC_CTRL_HALT_BIT]};
    end
  end

endmodule : mbc_top

// ===== verification/mbc_checker.sv
// port-level assertions for the branch control block
// assumes the halt bit sits at bit 0 of the register at offset zero
`timescale 1ns/1ps
`include "mbc_params.svh"
module mbc_checker (
  input wire logic                   i_ref_clk,
  input wire logic                   i_rst,
  input wire logic [4:0]             i_opcode,
  input wire logic                   i_test_polarity,
  input wire logic [2:0]             i_test_select,
  input wire logic [5:0]             i_data_field,
  input wire logic [5:0]             i_test,
  input wire logic                   i_condition_input,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic                   i_pwrite,
  input wire logic [`MBC_APB_AW-1:0] i_paddr,
  input wire logic [31:0]            i_pwdata,
  input wire logic                   o_pready,
  input wire logic [5:0]             o_microaddress_counter,
  input wire logic [5:0]             o_loop_count_register,
  input wire logic [5:0]             o_return_stack_register,
  input wire logic                   o_match_flag
);
  // ==========================================
  // instruction fields aligned to the outputs
  logic [4:0] o1, o2;
  logic [2:0] s1, s2;
  logic [5:0] d1, d2, t1, t2, pp, cp, rp;
  logic       p1, p2, c1, c2, mp, k1, k2, hq;
  wire  [5:0] pc = o_microaddress_counter;
  wire  [5:0] cn = o_loop_count_register;
  wire  [5:0] rt = o_return_stack_register;
  wire        ps = (s2 < 3'h6 ? t2[s2] : s2 == 3'h6 ? c2 : mp) ^ p2;
  always_ff @(posedge i_ref_clk) begin
    {o1, s1, d1, t1, p1, c1} <= {i_opcode, i_test_select, i_data_field, i_test, i_test_polarity, i_condition_input};
    {o2, s2, d2, t2, p2, c2} <= {o1, s1, d1, t1, p1, c1};
    {pp, cp, rp, mp} <= {pc, cn, rt, o_match_flag};
    k1 <= !i_rst && !hq;
    k2 <= k1;
  end
  // mirror of the halt bit
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) hq <= 1'b0;
    else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 12'h000) hq <= i_pwdata[0];
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  loop_branch_a: assert property (k2 && o2 == 5'h08 && cp != 6'h00
    |-> pc == d2 && cn == cp - 6'h01 && rt == rp) else $error("loop branch wrong");
  loop_done_a: assert property (k2 && o2 == 5'h08 && cp == 6'h00
    |-> pc == pp + 6'h01 && cn == cp && rt == rp) else $error("loop exit wrong");
  loop_clear_a: assert property (k2 && o2[4:2] == 3'h2 && !o2[0] && s2 == 3'h7 && cp != 6'h00
    |-> !o_match_flag) else $error("loop flag not cleared");
  nest_step_a: assert property (k2 && o2 == 5'h0a
    |-> cn == (cp == 6'h00 ? rp : cp - 6'h01) && rt == rp) else $error("nested loop wrong");
  wait_hold_a: assert property (k2 && o2 == 5'h1a && !ps
    |-> pc == pp && cn == cp && rt == rp && o_match_flag == mp) else $error("wait fail wrong");
  branch_clear_a: assert property (k2 && o2 == 5'h19 && ps && s2 == 3'h7
    |-> pc == d2 && !o_match_flag) else $error("branch flag wrong");
  zero_branch_a: assert property (k2 && o2 == 5'h0b
    |-> pc == (cp == 6'h00 ? d2 : pp + 6'h01)) else $error("zero branch wrong");
  masked_call_a: assert property (k2 && o2 == 5'h1e && ps
    |-> pc == (t2 & d2) && rt == pp + 6'h01) else $error("masked call wrong");
  count_wait_a: assert property (k2 && o2 == 5'h0c
    |-> cp != 6'h00 ? pc == pp && cn == cp - 6'h01 : pc == pp + 6'h01 && cn == d2) else $error("count wait wrong");
  cmp_set_a: assert property (k2 && o2[4:2] == 3'h4 && (t2 & d2) == {o2[1:0], p2, s2}
    |-> o_match_flag) else $error("compare did not set");
  reset_addr_a: assert property ($past(i_rst, 2) && $fell(i_rst)
    |=> pc == 6'h3f && cn == 6'h00 && rt == 6'h00 && !o_match_flag) else $error("reset state wrong");
  apb_ready_a: assert property (i_psel && i_penable && !o_pready
    |=> o_pready) else $error("apb ready late");
  loop_c: cover property (k2 && o2 == 5'h08 && cp != 6'h00);
  halt_c: cover property (hq && k1 == 1'b0);
  clear_c: cover property (k2 && o2 == 5'h19 && ps && s2 == 3'h7);
endmodule : mbc_checker

bind mbc_top mbc_checker u_chk (.*);

// ===== verification/mbc_test_source.sv
// test input unit standing at the far side of the block
// assumes the bench hands it the next values just after a rising edge
`timescale 1ns/1ps
module mbc_test_source (
  input  wire logic       i_ref_clk,
  input  wire logic [6:0] i_next,
  output logic [5:0]      o_test = 6'h00,
  output logic            o_condition_input = 1'b0
);
  // registered like an outside unit on the same clock
  always @(posedge i_ref_clk) begin
    {o_condition_input, o_test} <= i_next;
  end
endmodule : mbc_test_source

// ===== verification/test_mbc_top.sv
// self-checking bench for the branch control block
// assumes mbc_top, its bound checker and the test source model
`timescale 1ns/1ps
`include "mbc_params.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module test_mbc_top;
  logic        i_ref_clk = 0, i_rst = 1, i_test_polarity = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [4:0]  i_opcode = 5'h0d;
  logic [2:0]  i_test_select = 3'h0;
  logic [5:0]  i_data_field = 6'h00, i_test, pc, cn, rt;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, lf = 32'h23;
  logic        i_condition_input, o_pready, o_pslverr, o_match_flag, o_count_zero, mf, hl;
  logic [5:0]  o_microaddress_counter, o_loop_count_register, o_return_stack_register;
  logic [6:0]  nt = 7'h00;
  logic [18:0] q[$];
  logic [32:0] aq[$];
  logic [4:0]  sq[17] = '{5'h04, 5'h08, 5'h08, 5'h08, 5'h05, 5'h0a, 5'h0a, 5'h0a, 5'h0a,
                          5'h0c, 5'h0c, 5'h0c, 5'h0b, 5'h1b, 5'h1b, 5'h17, 5'h03};
  int          err_count = 0, total_checks = 0;

  mbc_top uut (.*);
  mbc_test_source src (.i_ref_clk(i_ref_clk), .i_next(nt), .o_test(i_test), .o_condition_input(i_condition_input));

  initial forever #50 i_ref_clk = ~i_ref_clk;

  // ==========================================
  // reference state, one note per taken edge
  always @(posedge i_ref_clk) begin : model
    logic [5:0] mk, np, nc, nr, ic, d;
    logic [4:0] o;
    logic [2:0] s;
    logic       nm, ps, z, cl;
    if (i_rst) begin
      {pc, cn, rt, mf, hl} = {6'h3f, 6'h00, 6'h00, 1'b0, 1'b0};
      q = {};
    end else begin
      {o, s, d} = {i_opcode, i_test_select, i_data_field};
      {mk, z, cl, ic} = {i_test & d, cn == 6'h00, s == 3'h7, pc + 6'h01};
      {np, nc, nr, nm} = {ic, cn, rt, mf};
      ps = (s < 3'h6 ? i_test[s] : s == 3'h6 ? i_condition_input : mf) ^ i_test_polarity;
      case (o)
        5'h00, 5'h01, 5'h02, 5'h03: if (ps) {np, nc, nr} = {rt, o[1] ? cn : d, o[0] ? cn : rt};
        5'h04, 5'h05, 5'h06, 5'h07: if (ps) {nc, nr} = {o[1] ? mk : d, o[0] ? cn : rt};
        5'h08, 5'h0a: if (!z) {np, nc, nm} = {d, cn - 6'h01, mf & ~cl};
          else if (o[1]) nc = rt;
        5'h09: if (ps) nc = cn - 6'h01;
        5'h0b: if (z) {np, nm} = {d, mf & ~cl};
        5'h0c, 5'h0e: if (!z) {np, nc} = {pc, cn - 6'h01};
          else nc = o[1] ? mk : d;
        5'h10, 5'h11, 5'h12, 5'h13: if (mk == {o[1:0], i_test_polarity, s}) nm = 1'b1;
        5'h14, 5'h15, 5'h16, 5'h17: if (ps) {nr, nc} = {ic, o == 5'h14 ? d : o == 5'h16 ? mk : o == 5'h17 ? rt : cn};
        5'h0d: nm = mf;
        default: if (ps) begin
          {np, nm} = {o == 5'h0f || o[4:1] == 4'hf ? mk : d, mf & ~cl};
          if (o[4:2] == 3'h7) {nr, nc} = {ic, o[0] ? rt : cn};
        end else if (o == 5'h18) np = rt;
        else if (o == 5'h1a || o == 5'h1b && !z) {np, nc} = {pc, o[0] ? cn - 6'h01 : cn};
      endcase
      if (!hl) {pc, cn, rt, mf} = {np, nc, nr, nm};
      if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 12'h000) hl = i_pwdata[0];
      q.push_back({pc, cn, rt, mf});
    end
  end

  // ==========================================
  // output watchers
  always @(negedge i_ref_clk) if (q.size() > 1) begin : mon
    logic [18:0] e;
    e = q.pop_front();
    `CHK("state", e, {o_microaddress_counter, o_loop_count_register, o_return_stack_register, o_match_flag})
    `CHK("zero", e[12:7] == 6'h00, o_count_zero)
  end
  always @(posedge i_ref_clk) if (i_psel && i_penable && o_pready) `CHK("apb", aq.pop_front(), {o_pslverr, o_prdata})

  // ==========================================
  // drivers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [32:0] st();
    return {8'h00, cn == 6'h00, mf, 1'b0, rt, 2'b00, cn, 2'b00, pc};
  endfunction : st
  task automatic op(input logic [4:0] o, input logic [31:0] r);
    @(posedge i_ref_clk);
    {i_opcode, i_test_polarity, i_test_select, i_data_field, nt} <= {o, r[0], r[3:1], r[9:4], r[16:10]};
  endtask : op
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    aq.push_back(e);
    @(posedge i_ref_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge i_ref_clk);
      if (o_pready === 1'b1) break;
    end
    if (n == 20) begin
      err_count++;
      stop_test();
    end
    {i_psel, i_penable} <= 2'b00;
  endtask : apb
  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // ==========================================
  // main sequence
  initial begin
    repeat (2) begin
      repeat (12) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(negedge i_ref_clk);
      `CHK("reset", 6'h3f, o_microaddress_counter)
      foreach (sq[k]) op(sq[k], 32'h1002c);
      for (int k = 0; k < 32; k++) repeat (4) begin
        lf = lfsr(lf);
        op(k[4:0], lf);
      end
      repeat (1500) begin
        lf = lfsr(lf);
        op(lf[31:27], lf);
      end
      op(5'h0d, lf);
      apb(1'b1, 12'h000, 32'h1, 33'h0);
      apb(1'b0, 12'h000, 32'h0, 33'h1);
      apb(1'b0, 12'h004, 32'h0, st());
      apb(1'b1, 12'h004, 32'hffffffff, 33'h0);
      apb(1'b0, 12'h004, 32'h0, st());
      apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 12'hffc, 32'h1, {1'b1, 32'h0});
      apb(1'b1, 12'h000, 32'h0, 33'h0);
      repeat (20) op(5'h0d, lf);
      i_rst <= 1'b1;
    end
    stop_test();
  end
endmodule : test_mbc_top
